/* io_cell_pkg.sv */
package io_cell_pkg;

    // Register bus geometry.
    localparam int          AXI_ADDR_W       = 4;
    localparam logic [3:0]  CTRL_OFFSET      = 4'h0;
    localparam logic [3:0]  STATUS_OFFSET    = 4'h4;
    localparam logic [1:0]  RESP_OKAY        = 2'h0;
    localparam logic [1:0]  RESP_SLVERR      = 2'h2;

    // Control register layout.
    localparam int          CTRL_W           = 6;
    localparam int          CTRL_IN_MODE_LSB = 0;
    localparam int          CTRL_OUT_MODE_LSB = 2;
    localparam int          CTRL_SR_ASYNC_BIT = 4;
    localparam int          CTRL_SR_VALUE_BIT = 5;
    localparam logic [5:0]  CTRL_RESET       = 6'h00;

    // Status register layout.
    localparam int          STAT_IN_A_BIT    = 0;
    localparam int          STAT_IN_B_BIT    = 1;
    localparam int          STAT_IN_CAP_BIT  = 2;
    localparam int          STAT_PAD_BIT     = 3;
    localparam int          STAT_SEL_BIT     = 4;

    // Positions of the pin inputs in the synchroniser vector.
    localparam int          SYNC_W           = 12;
    localparam int          IDX_PAD          = 0;
    localparam int          IDX_CAP_EN       = 1;
    localparam int          IDX_ICA          = 2;
    localparam int          IDX_ICB          = 3;
    localparam int          IDX_LOAD_EN      = 4;
    localparam int          IDX_OCA          = 5;
    localparam int          IDX_OCB          = 6;
    localparam int          IDX_OD           = 7;
    localparam int          IDX_ODA          = 8;
    localparam int          IDX_ODB          = 9;
    localparam int          IDX_SR           = 10;
    localparam int          IDX_INIT         = 11;

    typedef enum logic [1:0] {
        MODE_REG   = 2'b00,
        MODE_LATCH = 2'b01,
        MODE_DDR   = 2'b10
    } path_mode_t;

endpackage

/* pin_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module pin_sync
    import io_cell_pkg::*;
(
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire logic [SYNC_W-1:0] async_in,
    output logic      [SYNC_W-1:0] sync_out
);

    typedef struct packed {
        logic [SYNC_W-1:0] meta;
        logic [SYNC_W-1:0] stable;
    } sync_state_t;

    sync_state_t st_r;
    sync_state_t st_nxt;

    // The first stage feeds the second stage only.
    always_comb begin
        st_nxt.meta   = async_in;
        st_nxt.stable = st_r.meta;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign sync_out = st_r.stable;

endmodule
`default_nettype wire

/* io_cell.sv */
// Summary of operation
// - DDR input: register A samples pad on each rising edge of phase A.
// - DDR input: register B samples pad on each rising edge of phase B.
// - One input capture enable gates both DDR input registers together.
// - Synchronous set/reset forces input A at next A edge, B at next B edge.
// - Single-rate output register loads on clock edge only while load enable high.
// - Synchronous set/reset forces the output register at the clock edge.
// - Asynchronous set/reset forces output register and pad without a clock edge.
// - Global init pulse forces the registers to the configured value.
// - Output path offers a transparent latch passing data while open.
// - DDR output: register A captures its data on phase A rising edge.
// - DDR output: register B captures its data on phase B rising edge.
// - One output load enable gates both DDR output registers.
// - Synchronous set/reset forces output A at next A edge, B at next B edge.
// - Input path offers a transparent latch passing pad to captured input.
// - Asynchronous set/reset changes input registers without a clock edge.
`timescale 1ns/1ps
`default_nettype none
module io_cell
    import io_cell_pkg::*;
(
    input  wire logic                  aclk,
    input  wire logic                  aresetn,
    input  wire logic [AXI_ADDR_W-1:0] awaddr,
    input  wire logic                  awvalid,
    output logic                       awready,
    input  wire logic [31:0]           wdata,
    input  wire logic [3:0]            wstrb,
    input  wire logic                  wvalid,
    output logic                       wready,
    output logic [1:0]                 bresp,
    output logic                       bvalid,
    input  wire logic                  bready,
    input  wire logic [AXI_ADDR_W-1:0] araddr,
    input  wire logic                  arvalid,
    output logic                       arready,
    output logic [31:0]                rdata,
    output logic [1:0]                 rresp,
    output logic                       rvalid,
    input  wire logic                  rready,
    input  wire logic                  pad_in,
    input  wire logic                  input_capture_enable,
    input  wire logic                  in_clk_phase_a,
    input  wire logic                  in_clk_phase_b,
    input  wire logic                  output_load_enable,
    input  wire logic                  out_clk_phase_a,
    input  wire logic                  out_clk_phase_b,
    input  wire logic                  out_data,
    input  wire logic                  out_data_a,
    input  wire logic                  out_data_b,
    input  wire logic                  set_reset_ctl,
    input  wire logic                  global_init_pulse,
    output logic                       in_reg_a_q,
    output logic                       in_reg_b_q,
    output logic                       captured_input,
    output logic                       pad_out
);

    typedef struct packed {
        logic [CTRL_W-1:0]     ctrl;
        logic                  aw_got;
        logic [AXI_ADDR_W-1:0] aw_addr;
        logic                  w_got;
        logic [31:0]           w_data;
        logic [3:0]            w_strb;
        logic                  bvalid;
        logic [1:0]            bresp;
        logic                  rvalid;
        logic [31:0]           rdata;
        logic [1:0]            rresp;
        logic                  ia_prev;
        logic                  ib_prev;
        logic                  oa_prev;
        logic                  ob_prev;
        logic                  in_a;
        logic                  in_b;
        logic                  in_cap;
        logic                  out_a;
        logic                  out_b;
        logic                  out_sel;
        logic                  pad;
    } cell_state_t;

    cell_state_t       st_r;
    cell_state_t       st_nxt;
    logic [SYNC_W-1:0] s;
    path_mode_t        in_mode;
    path_mode_t        out_mode;
    logic              sr_async;
    logic              sr_val;
    logic              sr_s;
    logic              init_s;
    logic              sr_sync;
    logic              force_now;
    logic              rise_ia;
    logic              rise_ib;
    logic              rise_oa;
    logic              rise_ob;

    // Phase clocks, enables and data come from fabric on other clocks, so every
    // one of them is resynchronised with the same latency; data and clock stay
    // aligned as long as the fabric holds data steady between phase edges.
    pin_sync u_sync (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .async_in ({global_init_pulse, set_reset_ctl, out_data_b, out_data_a,
                    out_data, out_clk_phase_b, out_clk_phase_a, output_load_enable,
                    in_clk_phase_b, in_clk_phase_a, input_capture_enable, pad_in}),
        .sync_out (s)
    );

    // Edge register with synchronous set/reset taking priority over the enable.
    function automatic logic load_bit(input logic cur, input logic clk_edge,
                                      input logic en, input logic d,
                                      input logic clr, input logic clr_val);
        logic r;
        r = cur;
        if (clk_edge) begin
            if (clr) begin
                r = clr_val;
            end else if (en) begin
                r = d;
            end
        end
        return r;
    endfunction

    function automatic logic is_offset(input logic [AXI_ADDR_W-1:0] addr,
                                       input logic [AXI_ADDR_W-1:0] offs);
        return addr[AXI_ADDR_W-1:2] == offs[AXI_ADDR_W-1:2];
    endfunction

    assign in_mode   = path_mode_t'(st_r.ctrl[CTRL_IN_MODE_LSB +: 2]);
    assign out_mode  = path_mode_t'(st_r.ctrl[CTRL_OUT_MODE_LSB +: 2]);
    assign sr_async  = st_r.ctrl[CTRL_SR_ASYNC_BIT];
    assign sr_val    = st_r.ctrl[CTRL_SR_VALUE_BIT];
    assign sr_s      = s[IDX_SR];
    assign init_s    = s[IDX_INIT];
    assign sr_sync   = sr_s & ~sr_async;
    assign force_now = init_s | (sr_s & sr_async);
    assign rise_ia   = s[IDX_ICA] & ~st_r.ia_prev;
    assign rise_ib   = s[IDX_ICB] & ~st_r.ib_prev;
    assign rise_oa   = s[IDX_OCA] & ~st_r.oa_prev;
    assign rise_ob   = s[IDX_OCB] & ~st_r.ob_prev;

    assign awready = ~st_r.aw_got & ~st_r.bvalid;
    assign wready  = ~st_r.w_got & ~st_r.bvalid;
    assign arready = ~st_r.rvalid;

    always_comb begin
        st_nxt         = st_r;
        st_nxt.ia_prev = s[IDX_ICA];
        st_nxt.ib_prev = s[IDX_ICB];
        st_nxt.oa_prev = s[IDX_OCA];
        st_nxt.ob_prev = s[IDX_OCB];

        case (in_mode)
            MODE_DDR: begin
                st_nxt.in_a = load_bit(st_r.in_a, rise_ia, s[IDX_CAP_EN], s[IDX_PAD],
                                       sr_sync, sr_val);
                st_nxt.in_b = load_bit(st_r.in_b, rise_ib, s[IDX_CAP_EN], s[IDX_PAD],
                                       sr_sync, sr_val);
            end
            MODE_LATCH: begin
                if (s[IDX_ICA] && s[IDX_CAP_EN]) begin
                    st_nxt.in_cap = s[IDX_PAD];
                end
            end
            default: begin
                st_nxt.in_cap = load_bit(st_r.in_cap, rise_ia, s[IDX_CAP_EN], s[IDX_PAD],
                                         sr_sync, sr_val);
            end
        endcase

        case (out_mode)
            MODE_DDR: begin
                st_nxt.out_a = load_bit(st_r.out_a, rise_oa, s[IDX_LOAD_EN], s[IDX_ODA],
                                        sr_sync, sr_val);
                st_nxt.out_b = load_bit(st_r.out_b, rise_ob, s[IDX_LOAD_EN], s[IDX_ODB],
                                        sr_sync, sr_val);
                // With complementary phases the two edges never coincide; if
                // they do, phase B is taken as the later one.
                if (rise_oa) begin
                    st_nxt.out_sel = 1'b0;
                end
                if (rise_ob) begin
                    st_nxt.out_sel = 1'b1;
                end
            end
            MODE_LATCH: begin
                if (s[IDX_OCA] && s[IDX_LOAD_EN]) begin
                    st_nxt.out_a = s[IDX_OD];
                end
            end
            default: begin
                st_nxt.out_a = load_bit(st_r.out_a, rise_oa, s[IDX_LOAD_EN], s[IDX_OD],
                                        sr_sync, sr_val);
            end
        endcase

        // Global init and asynchronous set/reset act without any phase edge.
        if (force_now) begin
            st_nxt.in_a   = sr_val;
            st_nxt.in_b   = sr_val;
            st_nxt.in_cap = sr_val;
            st_nxt.out_a  = sr_val;
            st_nxt.out_b  = sr_val;
        end

        if (out_mode == MODE_DDR) begin
            st_nxt.pad = st_nxt.out_sel ? st_nxt.out_b : st_nxt.out_a;
        end else begin
            st_nxt.pad = st_nxt.out_a;
        end

        // Write address and data may arrive in either order.
        if (awvalid && awready) begin
            st_nxt.aw_got  = 1'b1;
            st_nxt.aw_addr = awaddr;
        end
        if (wvalid && wready) begin
            st_nxt.w_got  = 1'b1;
            st_nxt.w_data = wdata;
            st_nxt.w_strb = wstrb;
        end
        if (st_r.aw_got && st_r.w_got && !st_r.bvalid) begin
            st_nxt.aw_got = 1'b0;
            st_nxt.w_got  = 1'b0;
            st_nxt.bvalid = 1'b1;
            st_nxt.bresp  = RESP_OKAY;
            if (is_offset(st_r.aw_addr, CTRL_OFFSET)) begin
                if (st_r.w_strb[0]) begin
                    st_nxt.ctrl = st_r.w_data[CTRL_W-1:0];
                end
            end else if (!is_offset(st_r.aw_addr, STATUS_OFFSET)) begin
                st_nxt.bresp = RESP_SLVERR;
            end
        end
        if (st_r.bvalid && bready) begin
            st_nxt.bvalid = 1'b0;
        end

        if (arvalid && arready) begin
            st_nxt.rvalid = 1'b1;
            st_nxt.rdata  = 32'h0000_0000;
            st_nxt.rresp  = RESP_OKAY;
            if (is_offset(araddr, CTRL_OFFSET)) begin
                st_nxt.rdata[CTRL_W-1:0] = st_r.ctrl;
            end else if (is_offset(araddr, STATUS_OFFSET)) begin
                st_nxt.rdata[STAT_IN_A_BIT]   = st_r.in_a;
                st_nxt.rdata[STAT_IN_B_BIT]   = st_r.in_b;
                st_nxt.rdata[STAT_IN_CAP_BIT] = st_r.in_cap;
                st_nxt.rdata[STAT_PAD_BIT]    = st_r.pad;
                st_nxt.rdata[STAT_SEL_BIT]    = st_r.out_sel;
            end else begin
                st_nxt.rresp = RESP_SLVERR;
            end
        end
        if (st_r.rvalid && rready) begin
            st_nxt.rvalid = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_r      <= '0;
            st_r.ctrl <= CTRL_RESET;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign bresp          = st_r.bresp;
    assign bvalid         = st_r.bvalid;
    assign rdata          = st_r.rdata;
    assign rresp          = st_r.rresp;
    assign rvalid         = st_r.rvalid;
    assign in_reg_a_q     = st_r.in_a;
    assign in_reg_b_q     = st_r.in_b;
    assign captured_input = st_r.in_cap;
    assign pad_out        = st_r.pad;

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    property p_in_a_sample;
        (in_mode == MODE_DDR && rise_ia && s[IDX_CAP_EN] && !sr_s && !init_s)
            |=> (in_reg_a_q == $past(s[IDX_PAD]));
    endproperty
    a_in_a_sample: assert property (p_in_a_sample)
        else $error("input register A missed the pad value at its edge");

    property p_in_b_sample;
        (in_mode == MODE_DDR && rise_ib && s[IDX_CAP_EN] && !sr_s && !init_s)
            |=> (in_reg_b_q == $past(s[IDX_PAD]));
    endproperty
    a_in_b_sample: assert property (p_in_b_sample)
        else $error("input register B missed the pad value at its edge");

    property p_in_hold;
        (in_mode == MODE_DDR && !s[IDX_CAP_EN] && !sr_s && !init_s)
            |=> ($stable(in_reg_a_q) && $stable(in_reg_b_q));
    endproperty
    a_in_hold: assert property (p_in_hold)
        else $error("input register changed while capture was disabled");

    property p_in_sync_clear;
        (in_mode == MODE_DDR && rise_ib && sr_sync && !init_s)
            |=> (in_reg_b_q == $past(sr_val));
    endproperty
    a_in_sync_clear: assert property (p_in_sync_clear)
        else $error("input register B not set or reset at its edge");

    property p_out_reg_load;
        (out_mode == MODE_REG && !sr_s && !init_s && !rise_oa && !force_now)
            |=> $stable(pad_out);
    endproperty
    a_out_reg_load: assert property (p_out_reg_load)
        else $error("output register changed with no clock edge");

    property p_out_sync_sr;
        (out_mode == MODE_REG && rise_oa && sr_sync && !init_s)
            |=> (pad_out == $past(sr_val));
    endproperty
    a_out_sync_sr: assert property (p_out_sync_sr)
        else $error("pad missed the synchronous set or reset value");

    property p_async_force;
        (sr_s && sr_async) ##1 (sr_s && sr_async)
            |=> (pad_out == $past(sr_val, 2) && in_reg_a_q == $past(sr_val, 2));
    endproperty
    a_async_force: assert property (p_async_force)
        else $error("asynchronous set or reset did not force the registers");

    property p_global_init;
        init_s |=> (pad_out == $past(sr_val) && captured_input == $past(sr_val));
    endproperty
    a_global_init: assert property (p_global_init)
        else $error("global init did not reach the pad and input register");

    property p_out_latch;
        (out_mode == MODE_LATCH && s[IDX_OCA] && s[IDX_LOAD_EN] && !force_now)
            |=> (pad_out == $past(s[IDX_OD]));
    endproperty
    a_out_latch: assert property (p_out_latch)
        else $error("open output latch did not pass data to the pad");

    property p_ddr_out_b;
        (out_mode == MODE_DDR && rise_ob && s[IDX_LOAD_EN] && !sr_s && !init_s)
            |=> (pad_out == $past(s[IDX_ODB]));
    endproperty
    a_ddr_out_b: assert property (p_ddr_out_b)
        else $error("pad did not follow output register B after its edge");

    property p_ddr_out_a;
        (out_mode == MODE_DDR && rise_oa && !rise_ob && s[IDX_LOAD_EN] && !sr_s && !init_s)
            |=> (pad_out == $past(s[IDX_ODA]));
    endproperty
    a_ddr_out_a: assert property (p_ddr_out_a)
        else $error("pad did not follow output register A after its edge");

    property p_in_latch;
        (in_mode == MODE_LATCH && s[IDX_ICA] && s[IDX_CAP_EN] && !force_now)
            |=> (captured_input == $past(s[IDX_PAD]));
    endproperty
    a_in_latch: assert property (p_in_latch)
        else $error("open input latch did not pass the pad value");

endmodule
`default_nettype wire

/* fabric_model.sv */
`timescale 1ns/1ps
`default_nettype none
module fabric_model (
    input  wire logic       aclk,
    input  wire logic       aresetn,
    output logic            ph_a,
    output logic            ph_b,
    output logic [3:0]      cnt
);
    // One sixteen-cycle clock split into two complementary phases.
    // Both phases stand low in reset so that no stray edge reaches the cell.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt  <= 4'hf;
            ph_a <= 1'b0;
            ph_b <= 1'b0;
        end else begin
            cnt  <= cnt + 4'h1;
            ph_a <= (cnt + 4'h1) < 4'h8;
            ph_b <= (cnt + 4'h1) >= 4'h8;
        end
    end
endmodule
`default_nettype wire

/* io_cell_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module io_cell_tb
    import io_cell_pkg::*;
;
    logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic [3:0]  awaddr, araddr, wstrb, cnt;
    logic [31:0] wdata, rdata;
    logic [1:0]  bresp, rresp;
    logic        awready, wready, bvalid, arready, rvalid, ph_a, ph_b;
    logic        pad_in, cap_en, load_en, od, oda, odb, sr, gi;
    logic        ia, ib, cap, pad;
    int          err_count, num_checks;

    io_cell i_dut (
        .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready), .pad_in(pad_in), .input_capture_enable(cap_en),
        .in_clk_phase_a(ph_a), .in_clk_phase_b(ph_b), .output_load_enable(load_en),
        .out_clk_phase_a(ph_a), .out_clk_phase_b(ph_b), .out_data(od), .out_data_a(oda),
        .out_data_b(odb), .set_reset_ctl(sr), .global_init_pulse(gi), .in_reg_a_q(ia),
        .in_reg_b_q(ib), .captured_input(cap), .pad_out(pad)
    );
    fabric_model i_fabric (.aclk(aclk), .aresetn(aresetn), .ph_a(ph_a), .ph_b(ph_b), .cnt(cnt));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task close_out;
        $display("checks=%0d mismatches=%0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // Returns at the rising edge where the phase counter still shows n.
    task automatic to(input logic [3:0] n);
        do @(posedge aclk); while (cnt !== n);
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s,
                      input logic [1:0] er);
        logic aw_ok, w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(aw_ok && w_ok)) begin
            @(posedge aclk);
            if (awvalid && awready) begin
                aw_ok = 1'b1;
                awvalid <= 1'b0;
            end
            if (wvalid && wready) begin
                w_ok = 1'b1;
                wvalid <= 1'b0;
            end
        end
        do @(posedge aclk); while (bvalid !== 1'b1);
        bready <= 1'b0;
        chk(bresp, er);
    endtask

    task automatic rd(input logic [3:0] a, input logic [1:0] er, output logic [31:0] d);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge aclk); while (rvalid !== 1'b1);
        rready <= 1'b0;
        d = rdata;
        chk(rresp, er);
    endtask

    task automatic t_regs;
        logic [31:0] d;
        rd(CTRL_OFFSET, RESP_OKAY, d);
        chk(d, {26'h0, CTRL_RESET});
        wr(CTRL_OFFSET, 32'hffff_ffff, 4'hf, RESP_OKAY);
        rd(CTRL_OFFSET, RESP_OKAY, d);
        chk(d, 32'h0000_003f);
        wr(CTRL_OFFSET, 32'h0000_0000, 4'h0, RESP_OKAY);
        rd(CTRL_OFFSET, RESP_OKAY, d);
        chk(d, 32'h0000_003f);
        wr(STATUS_OFFSET, 32'hffff_ffff, 4'hf, RESP_OKAY);
        rd(4'h8, RESP_SLVERR, d);
        wr(4'hc, 32'h0000_0001, 4'hf, RESP_SLVERR);
        wr(CTRL_OFFSET, 32'h0000_0000, 4'hf, RESP_OKAY);
        rd(CTRL_OFFSET, RESP_OKAY, d);
        chk(d, 32'h0000_0000);
        $display("test regs done");
    endtask

    // Rows hold {enable, pad, set/reset, expected A, expected B}; each row is driven
    // at count 13 or 5, three counts before a phase edge, and checked after the next edge.
    task automatic t_ddr_in;
        logic [4:0] tbl [10] = '{5'h1a, 5'h1b, 5'h11, 5'h10, 5'h08,
                                 5'h08, 5'h1a, 5'h1b, 5'h1d, 5'h1c};
        wr(CTRL_OFFSET, 32'h0000_0002, 4'hf, RESP_OKAY);
        to(4'd13);
        for (int i = 0; i < 10; i++) begin
            cap_en <= tbl[i][4];
            pad_in <= tbl[i][3];
            sr <= tbl[i][2];
            to(i % 2 ? 4'd13 : 4'd5);
            chk(ia, tbl[i][1]);
            chk(ib, tbl[i][0]);
        end
        sr <= 1'b0;
        cap_en <= 1'b0;
        $display("test ddr_in done");
    endtask

    // Rows hold {load enable, data A, data B, set/reset, expected pad}.
    task automatic t_ddr_out;
        logic [4:0] tbl [10] = '{5'h19, 5'h18, 5'h14, 5'h15, 5'h08,
                                 5'h09, 5'h1d, 5'h1d, 5'h1e, 5'h1e};
        logic [31:0] d;
        wr(CTRL_OFFSET, 32'h0000_0008, 4'hf, RESP_OKAY);
        to(4'd13);
        for (int i = 0; i < 10; i++) begin
            load_en <= tbl[i][4];
            oda <= tbl[i][3];
            odb <= tbl[i][2];
            sr <= tbl[i][1];
            to(i % 2 ? 4'd13 : 4'd5);
            chk(pad, tbl[i][0]);
        end
        sr <= 1'b0;
        // Last phase edge was B and both registers are cleared, so status shows B selected.
        rd(STATUS_OFFSET, RESP_OKAY, d);
        chk(d, 32'h0000_0010);
        $display("test ddr_out done");
    endtask

    task automatic t_single_out;
        wr(CTRL_OFFSET, 32'h0000_0000, 4'hf, RESP_OKAY);
        to(4'd12);
        load_en <= 1'b1;
        od <= 1'b1;
        to(4'd5);
        chk(pad, 1'b1);
        load_en <= 1'b0;
        od <= 1'b0;
        to(4'd5);
        chk(pad, 1'b1);
        sr <= 1'b1;
        to(4'd15);
        chk(pad, 1'b1);
        to(4'd5);
        chk(pad, 1'b0);
        sr <= 1'b0;
        $display("test single_out done");
    endtask

    // Phase A stays low from count 8 on, so any change seen by count 9 needs no clock edge.
    task automatic t_async_init;
        wr(CTRL_OFFSET, 32'h0000_0030, 4'hf, RESP_OKAY);
        to(4'd4);
        sr <= 1'b1;
        to(4'd9);
        chk(pad, 1'b1);
        chk(cap, 1'b1);
        sr <= 1'b0;
        wr(CTRL_OFFSET, 32'h0000_0010, 4'hf, RESP_OKAY);
        to(4'd4);
        gi <= 1'b1;
        to(4'd9);
        chk(pad, 1'b0);
        chk(cap, 1'b0);
        gi <= 1'b0;
        $display("test async_init done");
    endtask

    task automatic t_latch;
        wr(CTRL_OFFSET, 32'h0000_0005, 4'hf, RESP_OKAY);
        to(4'd1);
        cap_en <= 1'b1;
        load_en <= 1'b1;
        od <= 1'b1;
        pad_in <= 1'b1;
        to(4'd6);
        chk(pad, 1'b1);
        chk(cap, 1'b1);
        to(4'd10);
        od <= 1'b0;
        pad_in <= 1'b0;
        to(4'd15);
        chk(pad, 1'b1);
        chk(cap, 1'b1);
        to(4'd5);
        chk(pad, 1'b0);
        chk(cap, 1'b0);
        $display("test latch done");
    endtask

    initial begin
        aclk = 1'b0;
        forever #12.5 aclk = ~aclk;
    end

    initial begin
        #100000;
        err_count++;
        $display("ERROR t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
        close_out;
    end

    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
        {awaddr, araddr, wstrb, wdata} = 44'h0;
        {pad_in, cap_en, load_en, od, oda, odb, sr, gi} = 8'h00;
        err_count = 0;
        num_checks = 0;
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_regs();
        t_ddr_in();
        t_ddr_out();
        t_single_out();
        t_async_init();
        t_latch();
        close_out;
    end
endmodule
`default_nettype wire
